// >>> rtl/csd_channel.v
// Cycle-steal data channel: priority, channel address registers and buffer,
// steal ring interlocked with the processor ring. Wishbone classic slave.
// Assumes adapter inputs synchronous to clk and one 100 MHz clock.
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "csd_regs.vh"
module csd_channel #(
   parameter NCH = 15,
   parameter AW  = 16
) (
   input  wire          clk,
   input  wire          rstn,
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [7:0]    wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o,
   input  wire [NCH-1:0] steal_req,
   input  wire [2:0]    steal_ctl,
   input  wire [AW-1:0] chan_data_bus,
   output reg  [NCH-1:0] steal_ack,
   output reg           any_steal,
   output reg  [AW-1:0] storage_addr,
   output reg           storage_addr_gate,
   output reg           proc_addr_block,
   output reg           xfer_to_out_bus,
   output reg           xfer_from_in_bus,
   output reg           addr_load_cycle,
   output reg           car_check,
   output reg  [2:0]    proc_time,
   output reg  [2:0]    steal_time
);
   // Code 010, 011 and 101 skip the X4 increment of the address register
   function incr_allowed;
      input [2:0] code;
      begin
         incr_allowed = !(code == `CSD_CC_LOAD_B || code == `CSD_CC_LOAD_IN ||
                          code == `CSD_CC_OUT_NOINC);
      end
   endfunction

   // Load codes 010 and 011 move a bus word into the address register
   function is_load_code;
      input [2:0] code;
      begin
         is_load_code = (code[2:1] == 2'b01);
      end
   endfunction

   reg  [AW-1:0]  car_mem [0:NCH-1];
   reg  [2:0]     lvl_ctl [0:NCH-1];
   reg  [AW-1:0]  cab_reg;
   reg  [NCH-1:0] lvl_reg;
   reg  [3:0]     win_reg;
   reg  [2:0]     code_reg;
   reg  [1:0]     osc_reg;
   reg            poll_reg;
   reg            poll_first_reg;
   reg            sampled_reg;
   reg            steal_reg;
   reg            delay_reg;
   reg            exec_io_pend_reg;
   reg            check_reg;
   reg  [`CSD_CTRL_W-1:0] ctrl_reg;

   wire [NCH-1:0] grant_oh;
   wire [3:0]     grant_idx;
   wire           grant_any;
   wire [2:0]     t_now;
   wire [2:0]     x_now;

   // Timing model: a four-clock oscillator cycle stands for one ring time.
   // Only phase A may step a ring, so the two rings share one advance pulse
   // and the interlock reduces to choosing which ring takes it.
   wire phase_a = (osc_reg == `CSD_OSC_A);
   wire phase_b = (osc_reg == `CSD_OSC_B);
   wire adv     = phase_a && !poll_reg;
   wire x_adv   = adv && steal_reg && !delay_reg;
   wire t_adv   = adv && !steal_reg;
   wire ring6   = steal_reg ? (x_now == `CSD_TIME_6) : (t_now == `CSD_TIME_6);
   wire scan_inhibit = ctrl_reg[`CSD_CTRL_LOAD] | ctrl_reg[`CSD_CTRL_DISPLAY] |
                       ctrl_reg[`CSD_CTRL_INIT_LOAD] | ctrl_reg[`CSD_CTRL_CLEAR];
   // Sample pulse driver fires on the second polling A pulse
   wire sample_fire = poll_reg && phase_a && poll_first_reg;
   wire [2:0] x_next = x_now + 3'h1;
   wire       gate_car = steal_reg && (x_now == `CSD_TIME_7 || x_now == `CSD_TIME_0 ||
                                       x_now == `CSD_TIME_1);
   wire       start_steal = t_adv && (t_now == `CSD_TIME_6) && grant_any;
   wire       end_steal   = x_adv && (x_now == `CSD_TIME_6) && !grant_any;

   // Priority is resolved from the registered level flops, never from the
   // live request lines, so a request that rises mid-cycle waits for a scan.
   csd_prio #(.N(NCH)) u_prio (
      .req   (lvl_reg),
      .grant (grant_oh),
      .idx   (grant_idx),
      .any   (grant_any)
   );

   // The processor ring is never loaded; it rests at 7 while a steal runs
   csd_ring u_tring (
      .clk      (clk),
      .rstn     (rstn),
      .step     (t_adv),
      .load     (1'b0),
      .load_val (3'h7),
      .time_reg (t_now)
   );

   csd_ring u_xring (
      .clk      (clk),
      .rstn     (rstn),
      .step     (x_adv),
      .load     (start_steal),
      .load_val (`CSD_TIME_7),
      .time_reg (x_now)
   );

   // Register bus decode. The ack term keeps a held request from being
   // taken twice while the master has not yet seen the answer.
   wire wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr    = wb_req && wb_we_i;
   wire wr_low   = wb_wr && wb_sel_i[0];
   wire init_wr  = wb_wr && (wb_adr_i == `CSD_INIT_OFS) && (&wb_sel_i[2:0]);
   wire [3:0] init_ch = wb_dat_i[`CSD_INIT_CH_MSB:`CSD_INIT_CH_LSB];
   // Check is judged on entry to X3 against the not yet incremented register
   wire chk_set  = x_adv && (x_next == `CSD_TIME_3) && (code_reg == `CSD_CC_CHECK) &&
                   (chan_data_bus != car_mem[win_reg]);

   // Scan interval: entering time 6 arms the polling latch; the second
   // phase A after that samples the requests and phase B then disarms it.
   // Oscillator phases, polling latch and scan
   always @(posedge clk) begin
      if (!rstn) begin
         osc_reg        <= 2'h0;
         poll_reg       <= 1'b0;
         poll_first_reg <= 1'b0;
         sampled_reg    <= 1'b0;
         lvl_reg        <= {NCH{1'b0}};
      end else begin
         osc_reg <= osc_reg + 2'h1;
         if (adv && ((steal_reg ? x_next : t_now + 3'h1) == `CSD_TIME_6) && !delay_reg) begin
            poll_reg       <= 1'b1;
            poll_first_reg <= 1'b0;
            sampled_reg    <= 1'b0;
         end else if (poll_reg && phase_a) begin
            poll_first_reg <= 1'b1;
            if (sample_fire) begin
               sampled_reg <= 1'b1;
               if (!scan_inhibit) begin
                  lvl_reg <= steal_req;
               end
            end
         end else if (poll_reg && phase_b && sampled_reg) begin
            poll_reg <= 1'b0;
         end
      end
   end

   // Steal mode, delay flop, acknowledge and level control flops
   integer k;
   always @(posedge clk) begin
      if (!rstn) begin
         steal_reg <= 1'b0;
         delay_reg <= 1'b0;
         win_reg   <= 4'h0;
         steal_ack <= {NCH{1'b0}};
         any_steal <= 1'b0;
         code_reg  <= 3'h0;
         for (k = 0; k < NCH; k = k + 1) begin
            lvl_ctl[k] <= 3'h0;
         end
      end else begin
         if (start_steal || (x_adv && x_now == `CSD_TIME_6 && grant_any)) begin
            steal_reg <= 1'b1;
            win_reg   <= grant_idx;
            steal_ack <= grant_oh;
            any_steal <= 1'b1;
         end else if (end_steal) begin
            steal_reg <= 1'b0;
            steal_ack <= {NCH{1'b0}};
            any_steal <= 1'b0;
         end
         // Delay flop: the step it swallows is the one that clears it, so
         // the held ring time lasts exactly one extra oscillator cycle.
         if (adv && steal_reg && delay_reg) begin
            delay_reg <= 1'b0;
         end else if (x_adv && x_next == `CSD_TIME_1 && ctrl_reg[`CSD_CTRL_TIMER]) begin
            delay_reg <= 1'b1;
         end else if ((start_steal || (x_adv && x_now == `CSD_TIME_6 && grant_any)) &&
                      exec_io_pend_reg) begin
            delay_reg <= 1'b1;
         end
         // Adapter holds its code while acknowledged; sample it at X0
         if (x_adv && x_next == `CSD_TIME_0) begin
            code_reg <= steal_ctl;
         end
         // Control flops of every level not acknowledged are held clear
         for (k = 0; k < NCH; k = k + 1) begin
            if (!steal_ack[k]) begin
               lvl_ctl[k] <= 3'h0;
            end else if (x_adv && x_next == `CSD_TIME_0) begin
               lvl_ctl[k] <= steal_ctl;
            end
         end
      end
   end

   // Own loop index so that each process drives its own variable
   integer m;

   // Address registers and buffer. A bus initialise in the same cycle as
   // a steal update of that channel wins; software initialises idle channels.
   always @(posedge clk) begin
      if (!rstn) begin
         cab_reg <= {AW{1'b0}};
         for (m = 0; m < NCH; m = m + 1) begin
            car_mem[m] <= {AW{1'b0}};
         end
      end else begin
         if (start_steal || (x_adv && x_next == `CSD_TIME_7)) begin
            cab_reg <= {AW{1'b0}};
         end else if (x_adv && x_now == `CSD_TIME_1) begin
            cab_reg <= car_mem[win_reg];
         end
         // Load codes clear at X3 and take the bus at X6; no increment
         // between, so the loaded word is what the next steal uses.
         if (x_adv && x_next == `CSD_TIME_3 && !code_reg[2] && code_reg[1]) begin
            car_mem[win_reg] <= {AW{1'b0}};
         end else if (x_adv && x_next == `CSD_TIME_4 && incr_allowed(code_reg)) begin
            car_mem[win_reg] <= car_mem[win_reg] + {{(AW-1){1'b0}}, 1'b1};
         end else if (x_adv && x_next == `CSD_TIME_6 && is_load_code(code_reg)) begin
            car_mem[win_reg] <= chan_data_bus;
         end
         if (init_wr && init_ch < NCH) begin
            car_mem[init_ch] <= wb_dat_i[AW-1:0];
         end
      end
   end

   // Storage address path and pin outputs, all registered
   always @(posedge clk) begin
      if (!rstn) begin
         storage_addr      <= {AW{1'b0}};
         storage_addr_gate <= 1'b0;
         proc_addr_block   <= 1'b0;
         xfer_to_out_bus   <= 1'b0;
         xfer_from_in_bus  <= 1'b0;
         addr_load_cycle   <= 1'b0;
         car_check         <= 1'b0;
         proc_time         <= 3'h7;
         steal_time        <= 3'h7;
      end else begin
         // The buffer, not the address register, carries X2..X6, so the
         // increment at X4 never reaches the storage address.
         storage_addr      <= gate_car ? car_mem[win_reg] : cab_reg;
         storage_addr_gate <= steal_reg;
         proc_addr_block   <= steal_reg;
         xfer_to_out_bus   <= steal_reg && (code_reg[2] || code_reg == 3'h0) &&
                              code_reg != `CSD_CC_CHECK;
         xfer_from_in_bus  <= steal_reg && code_reg == `CSD_CC_IN_BUF;
         addr_load_cycle   <= steal_reg && is_load_code(code_reg);
         car_check         <= chk_set;
         proc_time         <= t_now;
         steal_time        <= x_now;
      end
   end

   // Wishbone slave: one wait state, unmapped reads return zero
   always @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h00000000;
         ctrl_reg     <= `CSD_CTRL_RESET;
         exec_io_pend_reg <= 1'b0;
         check_reg    <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         if (wr_low && wb_adr_i == `CSD_CTRL_OFS) begin
            ctrl_reg <= wb_dat_i[`CSD_CTRL_W-1:0];
         end
         if (wr_low && wb_adr_i == `CSD_CTRL_OFS && wb_dat_i[`CSD_CTRL_EXEC_IO]) begin
            exec_io_pend_reg <= 1'b1;
         end else if (delay_reg) begin
            exec_io_pend_reg <= 1'b0;
         end
         // A mismatch in the clearing cycle is kept
         if (chk_set) begin
            check_reg <= 1'b1;
         end else if (wb_wr && wb_adr_i == `CSD_CHKCLR_OFS) begin
            check_reg <= 1'b0;
         end
         // Read data stands only with ack; zero otherwise eases bus muxing
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == `CSD_CTRL_OFS) begin
               wb_dat_o <= {26'h0, exec_io_pend_reg, ctrl_reg[`CSD_CTRL_W-2:0]};
            end else if (wb_adr_i == `CSD_STATUS_OFS) begin
               wb_dat_o <= {19'h0, win_reg, check_reg, delay_reg, steal_reg,
                            x_now, t_now};
            end else if (wb_adr_i == `CSD_LEVELS_OFS) begin
               wb_dat_o <= {{(32-NCH){1'b0}}, lvl_reg};
            end else if (wb_adr_i >= `CSD_CAR_BASE && wb_adr_i[1:0] == 2'h0 &&
                         (wb_adr_i - `CSD_CAR_BASE) < NCH * 4) begin
               wb_dat_o <= {{(32-AW){1'b0}}, car_mem[wb_adr_i[5:2]]};
            end
         end
      end
   end
endmodule // csd_channel
`default_nettype wire

// >>> rtl/csd_regs.vh
// Constants of the cycle-steal data channel: bus map, field positions, timing.
// Included by the channel top; holds definitions only.
`ifndef CSD_REGS_VH
`define CSD_REGS_VH

// Register byte offsets
`define CSD_CTRL_OFS     8'h00
`define CSD_STATUS_OFS   8'h04
`define CSD_LEVELS_OFS   8'h08
`define CSD_INIT_OFS     8'h0C
`define CSD_CHKCLR_OFS   8'h10
`define CSD_CAR_BASE     8'h40

// Control register bits
`define CSD_CTRL_LOAD    0
`define CSD_CTRL_DISPLAY 1
`define CSD_CTRL_INIT_LOAD 2
`define CSD_CTRL_CLEAR   3
`define CSD_CTRL_TIMER   4
`define CSD_CTRL_EXEC_IO 5
`define CSD_CTRL_W       6
`define CSD_CTRL_RESET   6'h00

// Status register fields
`define CSD_ST_T_LSB     0
`define CSD_ST_X_LSB     3
`define CSD_ST_STEAL     6
`define CSD_ST_DELAY     7
`define CSD_ST_CHECK     8
`define CSD_ST_WIN_LSB   9

// Channel initialise word: channel number and address portion
`define CSD_INIT_CH_LSB  16
`define CSD_INIT_CH_MSB  19

// Oscillator: four clocks per phase cycle, phase A then phase B
`define CSD_OSC_A        2'h0
`define CSD_OSC_B        2'h2

// Ring times
`define CSD_TIME_0       3'h0
`define CSD_TIME_1       3'h1
`define CSD_TIME_2       3'h2
`define CSD_TIME_3       3'h3
`define CSD_TIME_4       3'h4
`define CSD_TIME_6       3'h6
`define CSD_TIME_7       3'h7

// Steal control line codes
`define CSD_CC_LOAD_B    3'h2
`define CSD_CC_LOAD_IN   3'h3
`define CSD_CC_OUT_NOINC 3'h5
`define CSD_CC_CHECK     3'h6
`define CSD_CC_IN_BUF    3'h1

`endif

// >>> rtl/csd_ring.v
// Eight-step timing ring, stepped by a one-cycle advance pulse.
// Assumes the caller never steps and loads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module csd_ring (
   input  wire       clk,
   input  wire       rstn,
   input  wire       step,
   input  wire       load,
   input  wire [2:0] load_val,
   output reg  [2:0] time_reg
);
   reg [2:0] time_next;

   always @* begin
      time_next = time_reg;
      if (load) begin
         time_next = load_val;
      end else if (step) begin
         time_next = time_reg + 3'h1;
      end
   end

   // Both rings rest at time 7
   always @(posedge clk) begin
      if (!rstn) begin
         time_reg <= 3'h7;
      end else begin
         time_reg <= time_next;
      end
   end
endmodule // csd_ring
`default_nettype wire

// >>> rtl/csd_prio.v
// Fixed priority resolver: lowest index wins.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module csd_prio #(
   parameter N = 15
) (
   input  wire [N-1:0] req,
   output reg  [N-1:0] grant,
   output reg  [3:0]   idx,
   output wire         any
);
   integer i;

   assign any = |req;

   // Scan from the highest level down so that level 0 overrides all
   always @* begin
      grant = {N{1'b0}};
      idx   = 4'h0;
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            grant    = {N{1'b0}};
            grant[i] = 1'b1;
            idx      = i[3:0];
         end
      end
   end
endmodule // csd_prio
`default_nettype wire

// >>> verification/csd_sva.sv
// Port checker for the cycle-steal channel top.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module csd_chk #(
   parameter NCH = 15,
   parameter AW  = 16
) (
   input wire logic           clk,
   input wire logic           rstn,
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic           wb_we_i,
   input wire logic [7:0]     wb_adr_i,
   input wire logic [3:0]     wb_sel_i,
   input wire logic [31:0]    wb_dat_i,
   input wire logic [31:0]    wb_dat_o,
   input wire logic           wb_ack_o,
   input wire logic [NCH-1:0] steal_req,
   input wire logic [2:0]     steal_ctl,
   input wire logic [AW-1:0]  chan_data_bus,
   input wire logic [NCH-1:0] steal_ack,
   input wire logic           any_steal,
   input wire logic [AW-1:0]  storage_addr,
   input wire logic           storage_addr_gate,
   input wire logic           proc_addr_block,
   input wire logic           xfer_to_out_bus,
   input wire logic           xfer_from_in_bus,
   input wire logic           addr_load_cycle,
   input wire logic           car_check,
   input wire logic [2:0]     proc_time,
   input wire logic [2:0]     steal_time
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_ack_hot; $onehot0(steal_ack); endproperty
   a_ack_hot: assert property (p_ack_hot) else $error("two levels acknowledged");
   property p_ack_any; |steal_ack |-> any_steal; endproperty
   a_ack_any: assert property (p_ack_any) else $error("ack without any-steal");
   property p_rings; !($changed(proc_time) && $changed(steal_time)); endproperty
   a_rings: assert property (p_rings) else $error("both rings stepped");
   property p_t_held; steal_time != 3'h7 |-> proc_time == 3'h7; endproperty
   a_t_held: assert property (p_t_held) else $error("processor ring ran in steal");
   property p_gate; storage_addr_gate == proc_addr_block; endproperty
   a_gate: assert property (p_gate) else $error("gate and block disagree");
   property p_x_step; $changed(steal_time) |-> steal_time == $past(steal_time) + 3'h1; endproperty
   a_x_step: assert property (p_x_step) else $error("steal ring skipped");
   property p_buf_hold; steal_time inside {3'h4, 3'h5, 3'h6} |-> $stable(storage_addr); endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("address moved in X4..X6");
   property p_chk_pulse; car_check |=> !car_check; endproperty
   a_chk_pulse: assert property (p_chk_pulse) else $error("check longer than a cycle");
   property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
   property p_wb_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack held");
endmodule // csd_chk
bind csd_channel csd_chk #(.NCH(NCH), .AW(AW)) u_chk (
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .steal_req(steal_req), .steal_ctl(steal_ctl),
   .chan_data_bus(chan_data_bus), .steal_ack(steal_ack), .any_steal(any_steal),
   .storage_addr(storage_addr), .storage_addr_gate(storage_addr_gate),
   .proc_addr_block(proc_addr_block), .xfer_to_out_bus(xfer_to_out_bus),
   .xfer_from_in_bus(xfer_from_in_bus), .addr_load_cycle(addr_load_cycle),
   .car_check(car_check), .proc_time(proc_time), .steal_time(steal_time));
`default_nettype wire

// >>> verification/csd_adapters.sv
// Bank of device adapters on the steal levels.
// Assumes the bench pulses want for one cycle per transfer.
`timescale 1ns/1ps
`default_nettype none
module csd_adapters #(
   parameter NCH = 15,
   parameter AW  = 16
) (
   input  wire logic           clk,
   input  wire logic           rstn,
   input  wire logic [NCH-1:0] want,
   input  wire logic [2:0]     code,
   input  wire logic [AW-1:0]  data,
   input  wire logic [NCH-1:0] steal_ack,
   output var  logic [NCH-1:0] steal_req,
   output      logic [2:0]     steal_ctl,
   output      logic [AW-1:0]  chan_data_bus
);
   // One transfer per want: request dropped once acknowledged
   always @(posedge clk) begin
      if (!rstn)
         steal_req <= '0;
      else
         steal_req <= (steal_req | want) & ~steal_ack;
   end
   // Lines are not held outside the cycle: inverse shown so stale values fail
   assign steal_ctl     = |steal_ack ? code : ~code;
   assign chan_data_bus = |steal_ack ? data : ~data;
endmodule // csd_adapters
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the cycle-steal channel.
// Assumes the adapter model file and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "csd_regs.vh"
module tb_top;
   logic        clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, any_steal, gate, blk, to_out, from_in, ld_cyc, car_check;
   logic [14:0] want = 15'h0, steal_req, steal_ack;
   logic [2:0]  code = 3'h0, steal_ctl, proc_time, steal_time;
   logic [15:0] data = 16'h0, chan_data_bus, storage_addr;
   int          mismatches = 0, total_checks = 0;
   always #5 clk = ~clk;
   csd_adapters u_adp (.clk(clk), .rstn(rstn), .want(want), .code(code), .data(data),
      .steal_ack(steal_ack), .steal_req(steal_req), .steal_ctl(steal_ctl),
      .chan_data_bus(chan_data_bus));
   csd_channel u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .steal_req(steal_req),
      .steal_ctl(steal_ctl), .chan_data_bus(chan_data_bus), .steal_ack(steal_ack),
      .any_steal(any_steal), .storage_addr(storage_addr), .storage_addr_gate(gate),
      .proc_addr_block(blk), .xfer_to_out_bus(to_out), .xfer_from_in_bus(from_in),
      .addr_load_cycle(ld_cyc), .car_check(car_check), .proc_time(proc_time),
      .steal_time(steal_time));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wait_any(input logic lvl);
      for (int n = 0; n < 400 && any_steal !== lvl; n++)
         @(posedge clk);
   endtask
   // One transfer on a level; judges result address, buffer, check and decode
   task automatic steal(input int lv, input logic [2:0] cc, input logic [15:0] d,
                        input logic [15:0] car0);
      logic [31:0] q;
      logic [15:0] sa;
      logic [4:0]  dec;
      logic [15:0] exp_car;
      logic        seen;
      seen = 0;
      @(posedge clk);
      code <= cc;
      data <= d;
      want <= 15'h1 << lv;
      @(posedge clk);
      want <= 15'h0;
      wait_any(1'b1);
      chk(steal_ack, 32'h1 << lv);
      while (any_steal === 1'b1) begin
         if (steal_time === 3'h3) begin
            sa  = storage_addr;
            dec = {to_out, from_in, ld_cyc, gate, blk};
         end
         seen |= car_check;
         @(posedge clk);
      end
      chk(sa, car0);
      chk(dec, {cc inside {3'h0, 3'h4, 3'h5}, cc == 3'h1, cc inside {3'h2, 3'h3},
                2'b11});
      chk(seen, cc == 3'h6 && d != car0);
      wb(1'b0, `CSD_CAR_BASE + 8'(4 * lv), 32'h0, q);
      exp_car = cc inside {3'h2, 3'h3} ? d : (cc == 3'h5 ? car0 : car0 + 16'h1);
      chk(q, {16'h0, exp_car});
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      logic [31:0] q;
      logic [15:0] channel_address_reg;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({proc_time, steal_time, any_steal}, 32'h7E);
      wb(1'b0, `CSD_CTRL_OFS, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, `CSD_INIT_OFS, 32'h0003_1234, q);
      wb(1'b0, `CSD_CAR_BASE + 8'h0C, 32'h0, q);
      chk(q, 32'h1234);
      channel_address_reg = 16'h1234;
      for (int c = 0; c < 7; c++) begin
         steal(3, 3'(c), 16'h0500 + 16'(c), channel_address_reg);
         channel_address_reg = c inside {2, 3} ? 16'h0500 + 16'(c) : (c == 5 ? channel_address_reg : channel_address_reg + 16'h1);
      end
      wb(1'b1, `CSD_INIT_OFS, 32'h000E_FFFF, q);
      wb(1'b1, `CSD_CTRL_OFS, 32'h30, q);
      steal(14, 3'h0, 16'h0, 16'hFFFF);
      wb(1'b1, `CSD_CTRL_OFS, 32'h0, q);
      @(posedge clk);
      want <= 15'h0204;
      @(posedge clk);
      want <= 15'h0;
      wait_any(1'b1);
      chk(steal_ack, 32'h4);
      for (int n = 0; n < 400 && steal_ack !== 15'h0200; n++)
         @(posedge clk);
      chk(steal_ack, 32'h200);
      wait_any(1'b0);
      for (int b = 0; b < 4; b++) begin
         wb(1'b1, `CSD_CTRL_OFS, 32'h1 << b, q);
         @(posedge clk);
         want <= 15'h0020;
         @(posedge clk);
         want <= 15'h0;
         repeat (80) @(posedge clk);
         chk(any_steal, 32'h0);
         wb(1'b1, `CSD_CTRL_OFS, 32'h0, q);
         wait_any(1'b1);
         chk(steal_ack, 32'h20);
         wait_any(1'b0);
      end
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
